// File: bench/ccw_host_model.sv
// Host processor model: APB master that reaches the charge controller
module ccw_host_model
	import ccw_pkg::*;
(
	// Clock
	input  wire logic                  core_clk,
	// APB master side
	output logic                       psel,
	output logic                       penable,
	output logic                       pwrite,
	output logic [ccw_pkg::ADDR_W-1:0] paddr,
	output logic [31:0]                pwdata,
	input  wire logic [31:0]           prdata,
	input  wire logic                  pready,
	input  wire logic                  pslverr,
	// Answer wait ran out
	output logic                       tmo
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		{psel, penable, pwrite, paddr, pwdata, tmo} = '0;
	end
	// One transfer: setup, then access held until pready at an edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		tmo = (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
endmodule // ccw_host_model

// File: bench/tb_charge_cycle_watchdog_ctrl.sv
// Testbench of the charge cycle and watchdog controller
module tb_charge_cycle_watchdog_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import ccw_pkg::*;
	logic core_clk = 0, rst_n = 0, ce = 1, psel, penable, pwrite, pready, pslverr;
	logic indLvl, indOe, irqPulse, tmo, e;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [PIN_N-1:0] pinsIn = 12'h000;
	ccw_drv_t drv;
	int num_errors = 0, checks_done = 0, irqCount = 0, n;
	// Table of pin levels, phase and current target
	logic [15:0] steps [10] = '{16'h00d5, 16'h0096, 16'h001b, 16'h0c1b, 16'h041b,
		16'h041c, 16'h031b, 16'h041c, 16'h0430, 16'h401b};
	ccw_ctrl #(.SAFE_CYC(42'd200), .WDB_CYC(42'd100), .TOPA_CYC(42'd20),
		.BLNK_CYC(42'd4)) DUT (
		.core_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pinsIn, .drv, .indLvl, .indOe, .irqPulse);
	ccw_host_model host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .tmo);
	// Clock, 40 ns period
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	// Interrupt pulse counter
	always @(posedge core_clk) begin
		if (irqPulse === 1'b1) irqCount <= irqCount + 1;
	end
	// Verdict and end of run
	task automatic close_out;
		$display("Counts: %0d mismatches, %0d checks", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Compare and count
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Bus access; a lost answer ends the run
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		host.xfer(w, a, d, q, e);
		if (host.tmo !== 1'b0) begin
			num_errors++;
			close_out();
		end
	endtask
	// Read and compare masked bits
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		acc(1'b0, a, 32'h0);
		cmp(q & m, x);
	endtask
	// Count indicator level changes over 20 cycles
	task automatic flips;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			q[0] = indLvl;
			@(posedge core_clk);
			if (indLvl !== q[0]) n++;
		end
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rdc(REG_STAT, 32'h2f, 32'h20);
		rdc(REG_CTRL, 32'hffffffff, 32'h23);
		rdc(REG_CFG, 32'hffffffff, 32'h2120);
		acc(1'b0, 12'h00c, 32'h0);
		cmp(32'(e), 32'h1);
		acc(1'b1, REG_CTRL, 32'h2b);
		rdc(REG_STAT, 32'h20, 32'h0);
		acc(1'b1, REG_CFG, 32'h7fc5);
		repeat (30) @(posedge core_clk);
		acc(1'b1, REG_CTRL, 32'h2b);
		repeat (30) @(posedge core_clk);
		rdc(REG_STAT, 32'h20, 32'h0);
		repeat (200) @(posedge core_clk);
		rdc(REG_STAT, 32'h20, 32'h20);
		rdc(REG_CFG, 32'hffffffff, 32'h7fe0);
		acc(1'b1, REG_CTRL, 32'h4021);
		// Short, pre, fast, regulation, no term, done, recharge, done, pin off, pin on
		for (int i = 0; i < 10; i++) begin
			if (i == 5) begin
				acc(1'b1, REG_CTRL, 32'h4023);
				rdc(REG_STAT, 32'h13, 32'h13);
			end
			pinsIn <= steps[i][15:4];
			repeat (16) @(posedge core_clk);
			rdc(REG_STAT, 32'h3, 32'(steps[i][3:2]));
			cmp(32'(drv.currentSel), 32'(steps[i][1:0]));
		end
		cmp(32'(irqCount), 32'h3);
		cmp(32'({drv.passSwitchOn, indLvl, indOe}), 32'h5);
		cmp(32'({drv.coolReduce, drv.coolTo20, drv.warmTo41}), 32'h4);
		repeat (300) @(posedge core_clk);
		rdc(REG_STAT, 32'hf, 32'hc);
		flips();
		cmp(32'(n > 1), 32'h1);
		// Clock enable low freezes the blink
		ce <= 1'b0;
		@(posedge core_clk);
		flips();
		cmp(32'(n), 32'h0);
		ce <= 1'b1;
		acc(1'b1, REG_CTRL, 32'h0623);
		repeat (2) @(posedge core_clk);
		cmp(32'(indOe), 32'h0);
		close_out();
	end
endmodule // tb_charge_cycle_watchdog_ctrl

// File: common/ccw_pkg.sv
// Constants and types of the charge cycle and watchdog controller
package ccw_pkg;
	// ****************************************
	// Clock and time constants
	// ****************************************
	localparam longint CLK_HZ       = 25_000_000;          // Core clock rate in Hz
	localparam int     CNT_W        = 42;                  // Width of long counters
	localparam longint SAFETY_HOURS = 10;                  // Fast charge safety time
	localparam longint WD_SEC_A     = 40;                  // Watchdog period, code 01
	localparam longint WD_SEC_B     = 80;                  // Watchdog period, code 10
	localparam longint WD_SEC_C     = 160;                 // Watchdog period, code 11
	localparam longint TOP_MIN_A    = 15;                  // Top-off time, code 01
	localparam longint TOP_MIN_B    = 30;                  // Top-off time, code 10
	localparam longint TOP_MIN_C    = 45;                  // Top-off time, code 11
	localparam longint BLINK_MS     = 500;                 // Fault blink half period
	localparam logic [CNT_W-1:0] SAFETY_CYC = CNT_W'(SAFETY_HOURS * 3600 * CLK_HZ);
	localparam logic [CNT_W-1:0] WD_CYC_A   = CNT_W'(WD_SEC_A * CLK_HZ);
	localparam logic [CNT_W-1:0] WD_CYC_B   = CNT_W'(WD_SEC_B * CLK_HZ);
	localparam logic [CNT_W-1:0] WD_CYC_C   = CNT_W'(WD_SEC_C * CLK_HZ);
	localparam logic [CNT_W-1:0] TOP_CYC_A  = CNT_W'(TOP_MIN_A * 60 * CLK_HZ);
	localparam logic [CNT_W-1:0] TOP_CYC_B  = CNT_W'(TOP_MIN_B * 60 * CLK_HZ);
	localparam logic [CNT_W-1:0] TOP_CYC_C  = CNT_W'(TOP_MIN_C * 60 * CLK_HZ);
	localparam logic [CNT_W-1:0] BLINK_CYC  = CNT_W'(BLINK_MS * CLK_HZ / 1000);
	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W   = 12;                 // APB address width
	localparam logic [11:0] REG_CTRL = 12'h000;            // Control register
	localparam logic [11:0] REG_CFG  = 12'h004;            // Current and limit settings
	localparam logic [11:0] REG_STAT = 12'h008;            // Status, read only
	// ****************************************
	// Synchronised status pins
	// ****************************************
	localparam int PIN_CONV  = 0;                          // Converter running
	localparam int PIN_CE_N  = 1;                          // Charge enable pin, low active
	localparam int PIN_SHORT = 2;                          // Battery below 2.2 V
	localparam int PIN_LOW   = 3;                          // Battery below 3 V
	localparam int PIN_RCH_A = 4;                          // Below recharge threshold A
	localparam int PIN_RCH_B = 5;                          // Below recharge threshold B
	localparam int PIN_ITERM = 6;                          // Current below termination
	localparam int PIN_DPM   = 7;                          // Dynamic power limiting
	localparam int PIN_THERM = 8;                          // Thermal regulation
	localparam int PIN_TSOUT = 9;                          // Thermistor outside limits
	localparam int PIN_COOL  = 10;                         // Thermistor in cool zone
	localparam int PIN_WARM  = 11;                         // Thermistor in warm zone
	localparam int PIN_N     = 12;                         // Number of status pins
	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [1:0] topoffSetting;      // 00 off, else top-off time code
		logic       passSwitchOffDelay; // Delay before pass switch off
		logic       passSwitchResetEnable; // Push-button reset allowed
		logic       passSwitchDisable;  // Force pass switch off
		logic [1:0] indicatorPinControl; // 11 disables the indicator
		logic       coolCurrentSelect;  // Cool zone: 20 percent
		logic       warmVoltageSelect;  // Warm zone: 4.1 V
		logic       rechargeThresholdSelect; // Picks recharge comparator
		logic [1:0] wdPeriod;           // 00 disables the watchdog
		logic       wdKickBit;          // Self-clearing kick
		logic       regReset;           // Self-clearing register reset
		logic       termEnable;         // Automatic termination allowed
		logic       chargeEnableBit;    // Charging enabled
	} ccw_ctrl_t;
	typedef struct packed {
		logic [3:0] inputVoltageLimit;  // Input voltage limit code
		logic [4:0] inputCurrentLimit;  // Input current limit code
		logic [5:0] fastChargeCurrent;  // 64 mA steps
	} ccw_cfg_t;
	typedef enum logic [1:0] {
		PH_OFF = 2'b00, PH_PRE = 2'b01, PH_FAST = 2'b10, PH_DONE = 2'b11
	} ccw_phase_t;
	typedef enum logic [1:0] {
		CUR_NONE = 2'b00, CUR_SHORT = 2'b01, CUR_PRE = 2'b10, CUR_FAST = 2'b11
	} ccw_cur_t;
	typedef struct packed {
		logic     passSwitchOn;         // Battery pass switch closed
		ccw_cur_t currentSel;           // Current target in use
		logic     coolReduce;           // Reduce current, cool zone
		logic     coolTo20;             // Reduction to 20 percent
		logic     warmTo41;             // Regulate to 4.1 V
	} ccw_drv_t;
	localparam ccw_ctrl_t CTRL_DEF = 16'h0023;             // Enabled, term on, wd 10
	localparam ccw_cfg_t  CFG_DEF  = 15'h2120;             // 2.048 A fast charge
	localparam logic [1:0] FAULT_NONE  = 2'b00;            // No charge fault
	localparam logic [1:0] FAULT_TIMER = 2'b11;            // Safety timer expired
	localparam logic [1:0] IND_OFF     = 2'b11;            // Indicator disabled code
endpackage

// File: verilog/ccw_ctrl.sv
// Charge cycle sequencer with host watchdog and APB register slave
//
// Design decisions made here: the register offsets and the APB interface to the registers.
module ccw_ctrl
	import ccw_pkg::*;
#(
	parameter logic [ccw_pkg::CNT_W-1:0] SAFE_CYC = ccw_pkg::SAFETY_CYC,
	parameter logic [ccw_pkg::CNT_W-1:0] WDA_CYC  = ccw_pkg::WD_CYC_A,
	parameter logic [ccw_pkg::CNT_W-1:0] WDB_CYC  = ccw_pkg::WD_CYC_B,
	parameter logic [ccw_pkg::CNT_W-1:0] WDC_CYC  = ccw_pkg::WD_CYC_C,
	parameter logic [ccw_pkg::CNT_W-1:0] TOPA_CYC = ccw_pkg::TOP_CYC_A,
	parameter logic [ccw_pkg::CNT_W-1:0] TOPB_CYC = ccw_pkg::TOP_CYC_B,
	parameter logic [ccw_pkg::CNT_W-1:0] TOPC_CYC = ccw_pkg::TOP_CYC_C,
	parameter logic [ccw_pkg::CNT_W-1:0] BLNK_CYC = ccw_pkg::BLINK_CYC
) (
	// Clock, reset, enable
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [ccw_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Analog comparator and pin levels
	input  wire logic [ccw_pkg::PIN_N-1:0]     pinsIn,
	// Power stage controls
	output ccw_pkg::ccw_drv_t                  drv,
	// Charge indicator pin
	output logic                               indLvl,
	output logic                               indOe,
	// Host interrupt pulse
	output logic                               irqPulse
);
	import ccw_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [PIN_N-1:0] s1;            // Sync stage one
		logic [PIN_N-1:0] s2;            // Sync stage two
		logic [PIN_N-1:0] s3;            // Sync stage three
		logic [PIN_N-1:0] flt;           // Agreed pin levels
		ccw_ctrl_t        ctrl;          // Control register
		ccw_cfg_t         cfg;           // Settings register
		logic             hostMode;      // Low means default mode
		logic [CNT_W-1:0] wdCnt;         // Watchdog count
		ccw_phase_t       phase;         // Charge phase
		logic [1:0]       fault;         // Charge fault code
		logic [CNT_W-1:0] safeCnt;       // Safety count, half units
		logic             topRun;        // Top-off timer active
		logic [1:0]       topSet;        // Latched top-off setting
		logic [CNT_W-1:0] topCnt;        // Top-off count, half units
		logic             prevEn;        // Enable seen last cycle
		logic [CNT_W-1:0] blinkCnt;      // Blink divider
		logic             blinkLvl;      // Blink phase
		ccw_drv_t         drv;           // Power stage controls
		logic             indLvl;        // Indicator level
		logic             indOe;         // Indicator enable
		logic             irq;           // Interrupt pulse
		logic [31:0]      prdata;        // Read data
		logic             pready;        // Access phase answer
		logic             pslverr;       // Unmapped address
	} ccw_state_t;

	localparam ccw_state_t ST_RST = '{ctrl: CTRL_DEF, cfg: CFG_DEF, phase: PH_OFF,
		indLvl: 1'b1, indOe: 1'b1, default: '0};
	localparam logic [CNT_W-1:0] SAFE_LIM = {SAFE_CYC[CNT_W-2:0], 1'b0}; // Half units

	ccw_state_t       st_r;              // Registered state
	ccw_state_t       st_nxt;            // Next state
	logic [PIN_N-1:0] f;                 // Agreed pin levels
	logic             chgEnNow;          // Charging enabled now
	logic             enRise;            // Disable to enable
	logic             slowNow;           // Regulation active
	logic [1:0]       step;              // Count step
	logic             rechgLow;          // Below chosen recharge level
	logic             tsOk;              // Thermistor in range
	logic             startOk;           // Cycle may start
	logic             setupPh;           // APB setup phase
	logic             wrAcc;             // APB write completes
	logic             kickNow;           // Kick written
	logic             rstNow;            // Register reset written
	logic [CNT_W-1:0] wdLimit;           // Chosen watchdog count
	logic [CNT_W-1:0] topLimit;          // Chosen top-off count
	logic             wdExpire;          // Watchdog runs out

	// ****************************************
	// Decoded conditions
	// ****************************************
	// Qualifiers read from registered state and the live APB inputs
	always_comb begin
		f        = st_r.flt;
		chgEnNow = st_r.ctrl.chargeEnableBit & ~f[PIN_CE_N]
			& (st_r.cfg.fastChargeCurrent != '0);
		enRise   = chgEnNow & ~st_r.prevEn;
		slowNow  = f[PIN_DPM] | f[PIN_THERM];
		step     = slowNow ? 2'd1 : 2'd2;
		rechgLow = st_r.ctrl.rechargeThresholdSelect ? f[PIN_RCH_B] : f[PIN_RCH_A];
		tsOk     = ~f[PIN_TSOUT];
		startOk  = f[PIN_CONV] & chgEnNow & tsOk & (st_r.fault == FAULT_NONE)
			& ~st_r.ctrl.passSwitchDisable;
		setupPh  = psel & ~penable;
		wrAcc    = psel & penable & st_r.pready & pwrite & ~st_r.pslverr;
		kickNow  = wrAcc & (paddr == REG_CTRL) & pwdata[3];
		rstNow   = wrAcc & (paddr == REG_CTRL) & pwdata[2];
		// Watchdog period by field
		case (st_r.ctrl.wdPeriod)
			2'b01:   wdLimit = WDA_CYC;
			2'b10:   wdLimit = WDB_CYC;
			2'b11:   wdLimit = WDC_CYC;
			default: wdLimit = '0;
		endcase
		// Top-off time from latched setting
		case (st_r.topSet)
			2'b01:   topLimit = {TOPA_CYC[CNT_W-2:0], 1'b0};
			2'b10:   topLimit = {TOPB_CYC[CNT_W-2:0], 1'b0};
			2'b11:   topLimit = {TOPC_CYC[CNT_W-2:0], 1'b0};
			default: topLimit = '0;
		endcase
		wdExpire = st_r.hostMode & (st_r.ctrl.wdPeriod != 2'b00)
			& (st_r.wdCnt >= wdLimit) & ~kickNow;
	end

	// ****************************************
	// Next state
	// ****************************************
	// Pins, bus, watchdog, charge sequence
	always_comb begin
		st_nxt         = st_r;
		st_nxt.irq     = 1'b0;
		st_nxt.pready  = 1'b0;
		st_nxt.pslverr = 1'b0;
		// Three stage synchroniser, accept when stages two and three agree
		st_nxt.s1 = pinsIn;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < PIN_N; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.flt[i] = st_r.s2[i];
			end
		end
		st_nxt.prevEn = chgEnNow;
		// APB setup: capture read data, answer in next cycle
		if (setupPh) begin
			st_nxt.pready = 1'b1;
			case (paddr)
				REG_CTRL: st_nxt.prdata = {16'h0000, st_r.ctrl};
				REG_CFG:  st_nxt.prdata = {17'h00000, st_r.cfg};
				REG_STAT: st_nxt.prdata = {24'h000000, f[PIN_TSOUT], st_r.drv.passSwitchOn,
					~st_r.hostMode, st_r.topRun, st_r.fault, st_r.phase};
				default: begin
					st_nxt.prdata  = '0;
					st_nxt.pslverr = 1'b1;
				end
			endcase
		end
		// APB write completes
		if (wrAcc && paddr == REG_CTRL) begin
			st_nxt.ctrl           = ccw_ctrl_t'(pwdata[15:0]);
			st_nxt.ctrl.wdKickBit = 1'b0;
			st_nxt.ctrl.regReset  = 1'b0;
		end
		if (wrAcc && paddr == REG_CFG) begin
			st_nxt.cfg = ccw_cfg_t'(pwdata[14:0]);
		end
		// Watchdog: kick enters host mode and restarts the count
		if (kickNow) begin
			st_nxt.hostMode = 1'b1;
			st_nxt.wdCnt    = '0;
		end else if (wdExpire) begin
			st_nxt.hostMode = 1'b0;
			st_nxt.wdCnt    = '0;
			st_nxt.ctrl     = CTRL_DEF;
			st_nxt.ctrl.passSwitchDisable     = st_r.ctrl.passSwitchDisable;
			st_nxt.ctrl.passSwitchResetEnable = st_r.ctrl.passSwitchResetEnable;
			st_nxt.ctrl.passSwitchOffDelay    = st_r.ctrl.passSwitchOffDelay;
			st_nxt.cfg                   = CFG_DEF;
			st_nxt.cfg.inputCurrentLimit = st_r.cfg.inputCurrentLimit;
			st_nxt.cfg.inputVoltageLimit = st_r.cfg.inputVoltageLimit;
		end else if (st_r.hostMode && st_r.ctrl.wdPeriod != 2'b00) begin
			st_nxt.wdCnt = st_r.wdCnt + 1'b1;
		end
		// Register reset restores control and settings defaults and clears top-off
		if (rstNow) begin
			st_nxt.ctrl   = CTRL_DEF;
			st_nxt.cfg    = CFG_DEF;
			st_nxt.topRun = 1'b0;
			st_nxt.topCnt = '0;
		end
		// New enable clears fault and top-off
		if (enRise) begin
			st_nxt.fault  = FAULT_NONE;
			st_nxt.topRun = 1'b0;
			st_nxt.topCnt = '0;
		end
		// Charge sequence
		case (st_r.phase)
			PH_OFF: begin
				// Start with every qualifier met; a new enable skips the fault check
				if (startOk || (enRise && f[PIN_CONV] && tsOk
					&& !st_r.ctrl.passSwitchDisable)) begin
					st_nxt.phase   = f[PIN_LOW] ? PH_PRE : PH_FAST;
					st_nxt.safeCnt = '0;
				end
			end
			PH_PRE, PH_FAST: begin
				if (!chgEnNow || !f[PIN_CONV] || st_r.ctrl.passSwitchDisable) begin
					st_nxt.phase = PH_OFF;
				end else if (st_r.safeCnt >= SAFE_LIM) begin
					st_nxt.phase = PH_OFF;
					st_nxt.fault = FAULT_TIMER;
					st_nxt.irq   = 1'b1;
				end else if (tsOk) begin
					// Counting halves in regulation, stops while out of range
					st_nxt.safeCnt = st_r.safeCnt + step;
					st_nxt.phase   = f[PIN_LOW] ? PH_PRE : PH_FAST;
					if (st_r.phase == PH_FAST && st_r.ctrl.termEnable && f[PIN_ITERM]
						&& !rechgLow && !slowNow) begin
						st_nxt.phase  = PH_DONE;
						st_nxt.irq    = 1'b1;
						st_nxt.topSet = st_r.ctrl.topoffSetting;
						st_nxt.topRun = st_r.ctrl.topoffSetting != 2'b00;
						st_nxt.topCnt = '0;
					end
				end
			end
			PH_DONE: begin
				if (!chgEnNow || !f[PIN_CONV]) begin
					st_nxt.phase  = PH_OFF;
					st_nxt.topRun = 1'b0;
				end else if (st_r.topRun) begin
					// Top-off follows safety timer suspend and slow-down
					if (st_r.topCnt >= topLimit) begin
						st_nxt.topRun = 1'b0;
						st_nxt.irq    = 1'b1;
					end else if (tsOk) begin
						st_nxt.topCnt = st_r.topCnt + step;
					end
				end else if (rechgLow && tsOk) begin
					st_nxt.phase   = f[PIN_LOW] ? PH_PRE : PH_FAST;
					st_nxt.safeCnt = '0;
				end
			end
			default: st_nxt.phase = PH_OFF;
		endcase
		// Fault blink divider
		if (st_r.blinkCnt >= BLNK_CYC - 1'b1) begin
			st_nxt.blinkCnt = '0;
			st_nxt.blinkLvl = ~st_r.blinkLvl;
		end else begin
			st_nxt.blinkCnt = st_r.blinkCnt + 1'b1;
		end
		// Pass switch and current target follow the new phase, cool and warm controls follow the pins
		st_nxt.drv.passSwitchOn = (st_nxt.phase == PH_PRE || st_nxt.phase == PH_FAST)
			&& tsOk;
		case (st_nxt.phase)
			PH_PRE:  st_nxt.drv.currentSel = f[PIN_SHORT] ? CUR_SHORT : CUR_PRE;
			PH_FAST: st_nxt.drv.currentSel = CUR_FAST;
			default: st_nxt.drv.currentSel = CUR_NONE;
		endcase
		st_nxt.drv.coolReduce = f[PIN_COOL];
		st_nxt.drv.coolTo20   = f[PIN_COOL] & st_r.ctrl.coolCurrentSelect;
		st_nxt.drv.warmTo41   = f[PIN_WARM] & st_r.ctrl.warmVoltageSelect;
		// Indicator: low charging, blink on fault, else high
		if (st_nxt.phase == PH_PRE || st_nxt.phase == PH_FAST) begin
			st_nxt.indLvl = 1'b0;
		end else if (st_nxt.fault != FAULT_NONE) begin
			st_nxt.indLvl = st_r.blinkLvl;
		end else begin
			st_nxt.indLvl = 1'b1;
		end
		st_nxt.indOe = st_r.ctrl.indicatorPinControl != IND_OFF;
	end

	// ****************************************
	// State register
	// ****************************************
	// Synchronous reset to defaults, enable freezes everything
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= ST_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from state
	assign prdata   = st_r.prdata;
	assign pready   = st_r.pready;
	assign pslverr  = st_r.pslverr;
	assign drv      = st_r.drv;
	assign indLvl   = st_r.indLvl;
	assign indOe    = st_r.indOe;
	assign irqPulse = st_r.irq;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	kick_host_a: assert property ((ce && kickNow) |=> st_r.hostMode)
		else $error("kick did not enter host mode");
	wd_restore_a: assert property ((ce && wdExpire) |=>
		(!st_r.hostMode && st_r.ctrl.termEnable == CTRL_DEF.termEnable))
		else $error("watchdog expiry did not restore defaults");
	term_irq_a: assert property ($rose(st_r.phase == PH_DONE) |-> st_r.irq)
		else $error("termination without interrupt");
	term_off_a: assert property ((ce && st_r.phase == PH_FAST && !st_r.ctrl.termEnable)
		|=> st_r.phase != PH_DONE)
		else $error("termination while disabled");
	reg_noterm_a: assert property ((ce && st_r.phase == PH_FAST && slowNow)
		|=> st_r.phase != PH_DONE)
		else $error("termination during regulation");
	done_switch_a: assert property (st_r.phase == PH_DONE |-> !st_r.drv.passSwitchOn)
		else $error("pass switch on after termination");
	fault_hold_a: assert property (st_r.fault == FAULT_TIMER |-> st_r.phase == PH_OFF)
		else $error("charging with timer fault");
	ind_off_a: assert property ((ce && st_r.ctrl.indicatorPinControl == IND_OFF)
		|=> !st_r.indOe)
		else $error("indicator not disabled");
	top_start_a: assert property ($rose(st_r.topRun) |-> st_r.irq ##0 st_r.phase == PH_DONE)
		else $error("top-off start without interrupt");
	// Start qualification, thermistor, fault, bus pulse, cool zone and indicator checks
	conv_start_a: assert property ((ce && st_r.phase == PH_OFF && !f[PIN_CONV])
		|=> st_r.phase == PH_OFF)
		else $error("charge started without converter");
	ts_switch_a: assert property ((ce && !tsOk)
		|=> !st_r.drv.passSwitchOn)
		else $error("pass switch on with thermistor out of range");
	fault_irq_a: assert property ($rose(st_r.fault == FAULT_TIMER)
		|-> st_r.irq)
		else $error("timer fault without interrupt");
	bus_pulse_a: assert property ((ce && st_r.pready)
		|=> !st_r.pready)
		else $error("pready held longer than one cycle");
	cool_limit_a: assert property ((ce && f[PIN_COOL] && st_r.ctrl.coolCurrentSelect)
		|=> st_r.drv.coolTo20)
		else $error("cool zone reduction not applied");
	busy_ind_a: assert property (st_r.drv.passSwitchOn
		|-> !st_r.indLvl)
		else $error("indicator not low while charging");
endmodule // ccw_ctrl
